// file: design/cdtc_pkg.sv
// Constants shared by the countdown timer channel and its helpers
package cdtc_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CH1_IRQ_CLR = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_CH1_POUT = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_LOAD = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_POUT = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 8'hb0;

  // ----------------------------------------
  // Field positions, masks and resets
  // ----------------------------------------
  localparam int CTRL_IE_BIT = 0;
  localparam int CTRL_IMM_BIT = 1;
  localparam int CTRL_DIV_LSB = 2;
  localparam int CTRL_MODE_BIT = 5;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_SRC_LSB = 8;
  localparam logic [REG_W-1:0] CTRL_WMASK = 16'h03bf;
  localparam logic [REG_W-1:0] CTRL_RST = 16'h0000;
  localparam int POUT_VAL_BIT = 0;
  localparam int POUT_OE_BIT = 1;
  localparam int POUT_MODE_LSB = 2;
  localparam logic [REG_W-1:0] POUT_WMASK = 16'h000f;
  localparam logic [REG_W-1:0] POUT_RST = 16'h0000;
  localparam logic [REG_W-1:0] LOAD_RST = 16'h0000;
  localparam logic [REG_W-1:0] COUNT_RST = 16'h0000;
  localparam int STS_CH1_BIT = 1;
  localparam int STS_CH2_BIT = 2;

  // ----------------------------------------
  // Encodings and divider table
  // ----------------------------------------
  localparam logic [1:0] SRC_PS0 = 2'h2;
  localparam logic [1:0] SRC_PS1 = 2'h3;
  localparam logic [1:0] OMODE_LEVEL = 2'h0;
  localparam logic [1:0] OMODE_PULSE = 2'h1;
  localparam logic [1:0] OMODE_TOGGLE = 2'h2;
  localparam int DIV_CNT_W = 8;
  localparam logic [DIV_CNT_W-1:0] DIV_LIMIT [8] = '{
    8'h00, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h7f, 8'hff
  };

endpackage

// file: design/cdtc_clk_div.sv
// Channel clock divider producing a count tick
`timescale 1ns/1ps
module cdtc_clk_div #(
  parameter int CNT_W = cdtc_pkg::DIV_CNT_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Ratio and tick
  input wire logic [2:0] ratio,
  output logic tick
);
  import cdtc_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] limit;

  // ----------------------------------------
  // Divide chain
  // ----------------------------------------
  // A ratio lowered mid-count wraps at once instead of running to overflow
  assign limit = CNT_W'(DIV_LIMIT[ratio]);
  assign tick = (cnt_r >= limit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= tick ? '0 : cnt_r + 1'b1;
    end
  end

  chk_div_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && tick |=> cnt_r == '0) else $error("divider did not wrap");
  chk_div_unity: assert property (@(posedge aclk) disable iff (!aresetn)
    ratio == 3'h0 |-> tick) else $error("ratio one lost a tick");
  chk_div_four: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && tick && ratio == 3'h1 ##1 ce && ratio == 3'h1
    |-> !tick) else $error("divide by four too fast");

endmodule

// file: design/cdtc_port_out.sv
// Port output shaper for level, underflow and toggle modes
`timescale 1ns/1ps
module cdtc_port_out (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Settings and event
  input wire logic uflow,
  input wire logic [1:0] mode,
  input wire logic value,
  input wire logic out_en,
  input wire logic port_sel,
  // Pin
  output logic pin_o,
  output logic pin_oe
);
  import cdtc_pkg::*;

  logic toggle_r;
  logic pin_r;
  logic oe_r;

  // ----------------------------------------
  // Shaping
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle_r <= 1'b0;
    end else if (ce && uflow) begin
      toggle_r <= ~toggle_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_r <= 1'b0;
    end else if (ce) begin
      unique case (mode)
        OMODE_LEVEL: pin_r <= value;
        OMODE_PULSE: pin_r <= uflow;
        OMODE_TOGGLE: pin_r <= toggle_r ^ uflow;
        default: pin_r <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_r <= 1'b0;
    end else if (ce) begin
      oe_r <= out_en && port_sel;
    end
  end

  assign pin_o = pin_r;
  assign pin_oe = oe_r;

  chk_toggle_flip: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && uflow |=> toggle_r != $past(toggle_r)) else $error("no toggle");
  chk_oe_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !out_en |=> !pin_oe) else $error("pin driven while disabled");
  chk_level_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mode == OMODE_LEVEL |=> pin_o == $past(value))
    else $error("level mode lost value");

endmodule

// file: design/cdtc_channel.sv
// Countdown timer channel with AXI4-Lite register slave
`timescale 1ns/1ps
module cdtc_channel (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [cdtc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [cdtc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [cdtc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [cdtc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shared prescalers
  input wire logic ps0_tick,
  input wire logic ps1_tick,
  // Neighbour channel
  input wire logic ch1_irq_pending,
  output logic ch1_irq_clr,
  output logic [3:0] ch1_pout,
  // Port pin and interrupt
  input wire logic port_sel,
  output logic port_o,
  output logic port_oe,
  output logic irq
);
  import cdtc_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic aw_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic w_hold_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_mapped;
  logic ld_wr;
  logic ctrl_wr;
  logic pout_wr;
  logic clr_wr;
  logic ch1_clr_wr;
  logic ch1_pout_wr;
  logic [REG_W-1:0] load_r;
  logic [REG_W-1:0] ctrl_r;
  logic [REG_W-1:0] pout_r;
  logic [REG_W-1:0] ch1_pout_r;
  logic [REG_W-1:0] count_r;
  logic done_r;
  logic flag_r;
  logic ch1_clr_r;
  logic [REG_W-1:0] load_nxt;
  logic en;
  logic single;
  logic imm;
  logic ie;
  logic div_tick;
  logic src_tick;
  logic count_go;
  logic uflow;
  logic imm_ld;
  logic [REG_W-1:0] sts;
  logic [REG_W-1:0] rd_word;
  logic rd_hit;

  // ----------------------------------------
  // Byte-lane merge
  // ----------------------------------------
  function automatic logic [REG_W-1:0] merge16(
    input logic [REG_W-1:0] old,
    input logic [DATA_W-1:0] data,
    input logic [3:0] strb,
    input logic [REG_W-1:0] mask
  );
    logic [REG_W-1:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = data[7:0];
    end
    if (strb[1]) begin
      m[15:8] = data[15:8];
    end
    return m & mask;
  endfunction

  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  // Address and data are latched separately so either may come first
  // Ready drops with ce so that no write address or data handshake is seen while state is frozen
  assign s_axi_awready = ce && !aw_hold_r && !bvalid_r;
  assign s_axi_wready = ce && !w_hold_r && !bvalid_r;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = ce && (aw_hold_r || aw_take) && (w_hold_r || w_take);
  assign wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_hold_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= '0;
    end else if (ce) begin
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end else if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      if (wr_fire) begin
        w_hold_r <= 1'b0;
      end else if (w_take) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  assign ld_wr = wr_fire && hit(wr_addr, OFS_LOAD);
  assign ctrl_wr = wr_fire && hit(wr_addr, OFS_CTRL);
  assign pout_wr = wr_fire && hit(wr_addr, OFS_POUT);
  assign clr_wr = wr_fire && hit(wr_addr, OFS_IRQ_CLR);
  assign ch1_clr_wr = wr_fire && hit(wr_addr, OFS_CH1_IRQ_CLR);
  assign ch1_pout_wr = wr_fire && hit(wr_addr, OFS_CH1_POUT);
  // Writes to read-only words are accepted and dropped
  assign wr_mapped = ld_wr || ctrl_wr || pout_wr || clr_wr || ch1_clr_wr
    || ch1_pout_wr || hit(wr_addr, OFS_COUNT) || hit(wr_addr, OFS_IRQ_STS);

  // The response completes even while ce is low: the master has seen it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  assign load_nxt = merge16(load_r, wr_data, wr_strb, 16'hffff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_r <= LOAD_RST;
    end else if (ce && ld_wr) begin
      load_r <= load_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      pout_r <= POUT_RST;
      ch1_pout_r <= POUT_RST;
    end else if (ce) begin
      if (ctrl_wr) begin
        ctrl_r <= merge16(ctrl_r, wr_data, wr_strb, CTRL_WMASK);
      end
      if (pout_wr) begin
        pout_r <= merge16(pout_r, wr_data, wr_strb, POUT_WMASK);
      end
      if (ch1_pout_wr) begin
        ch1_pout_r <= merge16(ch1_pout_r, wr_data, wr_strb, POUT_WMASK);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch1_clr_r <= 1'b0;
    end else if (ce) begin
      ch1_clr_r <= ch1_clr_wr;
    end
  end

  assign ch1_irq_clr = ch1_clr_r;
  assign ch1_pout = ch1_pout_r[3:0];

  // ----------------------------------------
  // Count clock selection
  // ----------------------------------------
  assign en = ctrl_r[CTRL_EN_BIT];
  assign single = ctrl_r[CTRL_MODE_BIT];
  assign imm = ctrl_r[CTRL_IMM_BIT];
  assign ie = ctrl_r[CTRL_IE_BIT];

  cdtc_clk_div #(.CNT_W(DIV_CNT_W)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .ratio(ctrl_r[CTRL_DIV_LSB +: 3]),
    .tick(div_tick)
  );

  always_comb begin
    unique case (ctrl_r[CTRL_SRC_LSB +: 2])
      SRC_PS0: src_tick = ps0_tick;
      SRC_PS1: src_tick = ps1_tick;
      default: src_tick = div_tick;
    endcase
  end

  // ----------------------------------------
  // Down counter
  // ----------------------------------------
  assign count_go = en && !done_r && src_tick;
  assign uflow = ce && count_go && (count_r == '0);
  // Single mode always loads at once; cyclic only with the immediate bit
  assign imm_ld = ld_wr && (single || imm);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= COUNT_RST;
    end else if (ce) begin
      if (imm_ld) begin
        count_r <= load_nxt;
      end else if (uflow && !single) begin
        count_r <= load_r;
      end else if (count_go && count_r != '0) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // A halted single shot restarts only on a load or a fresh enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_r <= 1'b0;
    end else if (ce) begin
      if (!en || imm_ld) begin
        done_r <= 1'b0;
      end else if (uflow && single) begin
        done_r <= 1'b1;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      if (uflow) begin
        flag_r <= 1'b1;
      end else if (clr_wr) begin
        flag_r <= 1'b0;
      end
    end
  end

  assign irq = flag_r && ie;

  cdtc_port_out u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .uflow(uflow),
    .mode(pout_r[POUT_MODE_LSB +: 2]),
    .value(pout_r[POUT_VAL_BIT]),
    .out_en(pout_r[POUT_OE_BIT]),
    .port_sel(port_sel),
    .pin_o(port_o),
    .pin_oe(port_oe)
  );

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_comb begin
    sts = '0;
    sts[STS_CH1_BIT] = ch1_irq_pending;
    sts[STS_CH2_BIT] = flag_r && ie;
  end

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (hit(s_axi_araddr, OFS_LOAD)) begin
      rd_word = load_r;
    end else if (hit(s_axi_araddr, OFS_COUNT)) begin
      rd_word = count_r;
    end else if (hit(s_axi_araddr, OFS_CTRL)) begin
      rd_word = ctrl_r;
    end else if (hit(s_axi_araddr, OFS_POUT)) begin
      rd_word = pout_r;
    end else if (hit(s_axi_araddr, OFS_CH1_POUT)) begin
      rd_word = ch1_pout_r;
    end else if (hit(s_axi_araddr, OFS_IRQ_STS)) begin
      rd_word = sts;
    end else if (!hit(s_axi_araddr, OFS_IRQ_CLR)
        && !hit(s_axi_araddr, OFS_CH1_IRQ_CLR)) begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready = ce && !rvalid_r;
  assign ar_take = ce && s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= {{(DATA_W-REG_W){1'b0}}, rd_word};
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_uflow_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    uflow |=> flag_r) else $error("underflow did not set flag");
  chk_cyc_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    uflow && !single && !imm_ld |=> count_r == $past(load_r))
    else $error("cyclic reload wrong");
  chk_single_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    uflow && single && en && !imm_ld |=> done_r)
    else $error("single shot did not halt");
  chk_halt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    done_r && !ld_wr |=> $stable(count_r))
    else $error("halted counter moved");
  chk_imm_load: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ld_wr && (single || imm) |=> count_r == $past(load_nxt))
    else $error("immediate load missed");
  chk_defer_load: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ld_wr && !single && !imm && !count_go |=> $stable(count_r))
    else $error("deferred load applied early");
  chk_irq_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_wr && !uflow |=> !flag_r) else $error("clear write ignored");
  chk_irq_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    !ie |-> !irq && !sts[STS_CH2_BIT]) else $error("masked irq seen");
  chk_reset_ctrl: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> ctrl_r == '0 && pout_r == '0)
    else $error("control not zero after reset");

endmodule

// file: bench/test_countdown_timer_channel.sv
// Self-checking bench for the countdown timer channel
`timescale 1ns/1ps
module test_countdown_timer_channel;
  import cdtc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic ce = 1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, ch1_pout;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, ps0_tick = 0, ps1_tick = 0;
  logic ch1_irq_pending = 0, port_sel = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ch1_irq_clr, port_o, port_oe, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int failures = 0, checks = 0, cyc = 0, n;
  bit clr_seen = 0;

  cdtc_channel uut (
    .aclk, .aresetn, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ps0_tick, .ps1_tick, .ch1_irq_pending, .ch1_irq_clr, .ch1_pout,
    .port_sel, .port_o, .port_oe, .irq
  );

  // ----------------------------------------
  // Clock, watchdog and bus tasks
  // ----------------------------------------
  initial begin
    forever #20 aclk = ~aclk;
  end

  // Pulse on the neighbour clear is one cycle, so latch it
  always @(posedge aclk) begin
    cyc++;
    if (ch1_irq_clr === 1'b1) clr_seen <= 1;
    if (cyc == 40000) begin
      failures++;
      results();
    end
  end

  task results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data may be taken on different edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rdr(input logic [7:0] a);
    bit ar;
    ar = 1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (ar && s_axi_arready) begin
        ar = 0;
        s_axi_arvalid <= 0;
      end
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    rdr(a);
    cmp(nm, e, rd);
    cmp({nm, " resp"}, RESP_OKAY, rs);
  endtask

  task automatic tk(input bit which, input int k);
    repeat (k) begin
      @(posedge aclk);
      if (which) ps1_tick <= 1;
      else ps0_tick <= 1;
      @(posedge aclk);
      ps0_tick <= 0;
      ps1_tick <= 0;
    end
  endtask

  // Cycles to the next pin event: rising pulse, or any change
  task automatic edge_wait(input bit tog, output int k);
    logic p;
    k = 0;
    p = port_o;
    forever begin
      @(posedge aclk);
      k++;
      if (tog ? port_o !== p : (port_o === 1'b1 && p !== 1'b1)) break;
      p = port_o;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rc("ctrl", OFS_CTRL, 0);
    rc("pout", OFS_POUT, 0);
    rc("load", OFS_LOAD, 0);
    rc("count", OFS_COUNT, 0);
    wr(8'h60, 32'h1);
    cmp("unmapped wr", RESP_SLVERR, rs);
    rdr(8'h60);
    cmp("unmapped rd", RESP_SLVERR, rs);
    wr(OFS_POUT, 32'hffff);
    rc("pout mask", OFS_POUT, 32'h000f);
    cmp("oe", 1, port_oe);
    cmp("mode 11", 0, port_o);
    wr(OFS_POUT, 32'h0003);
    repeat (2) @(posedge aclk);
    cmp("level", 1, port_o);
    port_sel <= 0;
    repeat (3) @(posedge aclk);
    cmp("oe off", 0, port_oe);
    port_sel <= 1;
    wr(OFS_CTRL, 32'h0002);
    wr(OFS_LOAD, 32'h0040);
    rc("imm load", OFS_COUNT, 32'h0040);
    wr(OFS_CTRL, 0);
    wr(OFS_LOAD, 32'h0007);
    rc("deferred", OFS_COUNT, 32'h0040);
    rc("load rb", OFS_LOAD, 32'h0007);
    wr(OFS_CTRL, 32'h0200);
    tk(0, 4);
    rc("stopped", OFS_COUNT, 32'h0040);
    wr(OFS_CTRL, 32'h0280);
    tk(1, 4);
    tk(0, 4);
    rc("ps0", OFS_COUNT, 32'h003c);
    wr(OFS_CTRL, 32'h0380);
    tk(0, 2);
    tk(1, 2);
    rc("ps1", OFS_COUNT, 32'h003a);
    // Ticks offered while ce is low must be lost
    ce <= 0;
    tk(1, 2);
    ce <= 1;
    rc("ce hold", OFS_COUNT, 32'h003a);
    wr(OFS_CTRL, 32'h0020);
    wr(OFS_LOAD, 5);
    rc("single load", OFS_COUNT, 5);
    wr(OFS_CTRL, 32'h00a1);
    n = 0;
    while (irq !== 1'b1 && n < 30) begin
      @(posedge aclk);
      n++;
    end
    cmp("irq", 1, irq);
    rc("halted", OFS_COUNT, 0);
    rc("sts", OFS_IRQ_STS, 32'h4);
    wr(OFS_CTRL, 32'h00a0);
    @(posedge aclk);
    cmp("masked", 0, irq);
    rc("sts masked", OFS_IRQ_STS, 0);
    wr(OFS_CTRL, 32'h00a1);
    wr(OFS_IRQ_CLR, 32'h5a5a);
    @(posedge aclk);
    cmp("cleared", 0, irq);
    repeat (20) @(posedge aclk);
    rc("still halted", OFS_COUNT, 0);
    cmp("no refire", 0, irq);
    wr(OFS_CTRL, 0);
    wr(OFS_POUT, 32'h0006);
    // First gaps after a ratio change are skipped: divider phase is free
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CTRL, 32'h0080 | (c << 2));
      edge_wait(0, n);
      edge_wait(0, n);
      edge_wait(0, n);
      cmp("period", 6 * (c == 0 ? 1 : 2 << c), n);
    end
    wr(OFS_CTRL, 32'h0081);
    edge_wait(0, n);
    @(posedge aclk);
    cmp("cyclic irq", 1, irq);
    wr(OFS_POUT, 32'h000a);
    edge_wait(1, n);
    edge_wait(1, n);
    edge_wait(1, n);
    cmp("toggle", 6, n);
    wr(OFS_CH1_POUT, 32'h0005);
    @(posedge aclk);
    cmp("ch1 pout", 4'h5, ch1_pout);
    rc("ch1 rb", OFS_CH1_POUT, 5);
    wr(OFS_CH1_IRQ_CLR, 0);
    repeat (2) @(posedge aclk);
    cmp("ch1 clr", 1, clr_seen);
    ch1_irq_pending <= 1;
    wr(OFS_CTRL, 0);
    rc("sts ch1", OFS_IRQ_STS, 32'h2);
    // Second reset in mid-run
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rc("ctrl rst", OFS_CTRL, 0);
    rc("pout rst", OFS_POUT, 0);
    cmp("pin rst", 0, port_o);
    wr(OFS_POUT, 32'h000a);
    repeat (2) @(posedge aclk);
    cmp("toggle rst", 0, port_o);
    cmp("oe on", 1, port_oe);
    wr(OFS_POUT, 32'h0008);
    repeat (2) @(posedge aclk);
    cmp("oe bit off", 0, port_oe);
    results();
  end
endmodule
